// *** common/ide_pkg.sv ***
/*
 * constants, encodings and state type of the increment/decrement/branch/or
 * execution block. assumes a 13-bit instruction word and an 8-bit data path.
 */
package ide_pkg;

    localparam int INSTR_W = 13;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 6;
    localparam int PC_W = 9;

    // instruction word fields
    localparam int DEST_BIT = 6;
    localparam int REG_OP_LSB = 7;
    localparam int JUMP_OP_LSB = 9;
    localparam int IMM_OP_LSB = 8;

    // register-operand opcodes, word bits 12:7
    localparam logic [5:0] OPC_DECREMENT = 6'h03;
    localparam logic [5:0] OPC_DECREMENT_SKIP = 6'h0B;
    localparam logic [5:0] OPC_INCREMENT = 6'h0A;
    localparam logic [5:0] OPC_INCREMENT_SKIP = 6'h0F;
    localparam logic [5:0] OPC_OR_REG = 6'h04;
    // jump opcode, word bits 12:9; or-immediate opcode, word bits 12:8
    localparam logic [3:0] OPC_JUMP = 4'hA;
    localparam logic [4:0] OPC_OR_IMM = 5'h0D;

    // reset values
    localparam logic [DATA_W-1:0] ACCUM_RESET = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 9'h000;
    localparam logic ZERO_RESET = 1'h0;

    // alu operations
    typedef enum logic [2:0] {
        IDE_ALU_PASS = 3'h0,
        IDE_ALU_DEC = 3'h1,
        IDE_ALU_INC = 3'h2,
        IDE_ALU_OR = 3'h3
    } ide_alu_op_t;

    // execution state, one-hot
    typedef enum logic [1:0] {
        IDE_EXEC = 2'h1,
        IDE_NOP_SLOT = 2'h2
    } ide_state_t;

endpackage

// *** common/ide_alu_if.sv ***
/*
 * carrier between the execution core and its arithmetic unit.
 * assumes both ends sit on the same clock; the path is combinational.
 */
`timescale 1ns/1ns
interface ide_alu_if import ide_pkg::*; ();
    ide_alu_op_t op;
    logic [DATA_W-1:0] operand_a;
    logic [DATA_W-1:0] operand_b;
    logic [DATA_W-1:0] result;
    logic result_zero;

    modport core (output op, output operand_a, output operand_b,
                  input result, input result_zero);
    modport alu (input op, input operand_a, input operand_b,
                 output result, output result_zero);
endinterface

// *** design/ide_alu.sv ***
/*
 * 8-bit arithmetic unit: pass, decrement, increment, inclusive or.
 * assumes the core drives the operation and operands in the same cycle.
 */
`timescale 1ns/1ns
module ide_alu import ide_pkg::*; (
    ide_alu_if.alu bus
);

    // wrap-around arithmetic, 8 bits kept on purpose
    always_comb begin
        unique case (bus.op)
            IDE_ALU_DEC: bus.result = DATA_W'(bus.operand_a - 8'h01);
            IDE_ALU_INC: bus.result = DATA_W'(bus.operand_a + 8'h01);
            IDE_ALU_OR: bus.result = bus.operand_a | bus.operand_b;
            default: bus.result = bus.operand_a;
        endcase
    end

    // all-zero detect on the full byte
    assign bus.result_zero = (bus.result == 8'h00);

endmodule // ide_alu

// *** design/ide_core.sv ***
/*
 * execution core for decrement, increment, their skip forms, jump and the two
 * or forms. holds the accumulator, zero flag and program counter.
 * the skip and jump no-op slot is a state of its own rather than a flush.
 * assumes a file register array outside with a combinational read port and a
 * write port sampled on the clock; instructions arrive prefetched, one per cycle.
 */
`timescale 1ns/1ns
module ide_core import ide_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire logic [INSTR_W-1:0] instr_word,
    input wire logic [DATA_W-1:0] file_rdata,
    output logic instr_taken,
    output logic [ADDR_W-1:0] file_raddr,
    output logic file_we,
    output logic [ADDR_W-1:0] file_waddr,
    output logic [DATA_W-1:0] file_wdata,
    output logic [DATA_W-1:0] accumulator,
    output logic zero_flag,
    output logic [PC_W-1:0] program_counter,
    output logic nop_slot
);

    // registered state of the core
    ide_state_t state_reg;
    ide_state_t state_next;
    logic [DATA_W-1:0] accum_reg;
    logic zero_reg;
    logic [PC_W-1:0] pc_reg;
    logic we_reg;
    logic [ADDR_W-1:0] waddr_reg;
    logic [DATA_W-1:0] wdata_reg;

    // decoded fields
    logic [5:0] reg_opc;
    logic [ADDR_W-1:0] reg_addr;
    logic dest_file;
    logic [DATA_W-1:0] imm_byte;
    logic [PC_W-1:0] jump_target;
    logic exec;
    // one strobe per decoded instruction, each already qualified by exec
    logic is_dec;
    logic is_dec_skip;
    logic is_inc;
    logic is_inc_skip;
    logic is_or_reg;
    logic is_jump;
    logic is_or_imm;
    logic is_reg_op;
    // control derived from the decode
    logic writes_zero;
    logic skip_taken;
    logic [DATA_W-1:0] file_value;

    // the arithmetic unit is purely combinational; its result is only ever
    // captured by the registers below, never sent straight to a port
    ide_alu_if alu_bus ();

    ide_alu u_alu (
        .bus (alu_bus)
    );

    // field extraction; every field is cut from the same word, and only the
    // decode below decides which of them counts
    assign reg_opc = instr_word[INSTR_W-1:REG_OP_LSB];
    assign reg_addr = instr_word[ADDR_W-1:0];
    assign dest_file = instr_word[DEST_BIT];
    assign imm_byte = instr_word[DATA_W-1:0];
    assign jump_target = instr_word[PC_W-1:0];

    // an instruction executes only in the normal slot;
    // a word in the no-op slot fails this and so reaches none of the strobes
    assign exec = instr_valid && (state_reg == IDE_EXEC);

    // opcode decode; anything else is outside this group and acts as a no-op here.
    // the jump and or-immediate codes sit in slices of the register-operand code
    // space that no register-operand opcode uses, so at most one strobe is high
    assign is_dec = exec && (reg_opc == OPC_DECREMENT);
    assign is_dec_skip = exec && (reg_opc == OPC_DECREMENT_SKIP);
    assign is_inc = exec && (reg_opc == OPC_INCREMENT);
    assign is_inc_skip = exec && (reg_opc == OPC_INCREMENT_SKIP);
    assign is_or_reg = exec && (reg_opc == OPC_OR_REG);
    assign is_jump = exec && (instr_word[INSTR_W-1:JUMP_OP_LSB] == OPC_JUMP);
    assign is_or_imm = exec && (instr_word[INSTR_W-1:IMM_OP_LSB] == OPC_OR_IMM);
    assign is_reg_op = is_dec || is_dec_skip || is_inc || is_inc_skip || is_or_reg;

    // read the file register, forwarding a write still in flight so that
    // back-to-back instructions on one address see the new value;
    // without it a decrement-skip loop would count the same value twice
    assign file_raddr = reg_addr;
    assign file_value = (we_reg && (waddr_reg == reg_addr)) ? wdata_reg : file_rdata;

    // operand and operation selection for the arithmetic unit;
    // operand b is always the accumulator, only the immediate or swaps operand a
    always_comb begin
        alu_bus.operand_a = file_value;
        alu_bus.operand_b = accum_reg;
        alu_bus.op = IDE_ALU_PASS;
        if (is_dec || is_dec_skip) begin
            alu_bus.op = IDE_ALU_DEC;
        end else if (is_inc || is_inc_skip) begin
            alu_bus.op = IDE_ALU_INC;
        end else if (is_or_reg) begin
            alu_bus.op = IDE_ALU_OR;
        end else if (is_or_imm) begin
            alu_bus.operand_a = imm_byte;
            alu_bus.op = IDE_ALU_OR;
        end
    end

    // skip forms leave the zero flag alone; the jump touches no flag;
    // the or-immediate does update it, like the register or
    assign writes_zero = is_dec || is_inc || is_or_reg || is_or_imm;

    // skip on a zero result throws away the word already fetched;
    // result_zero is the value about to be stored, so the test sees the new count
    assign skip_taken = (is_dec_skip || is_inc_skip) && alu_bus.result_zero;

    // state: a taken skip or a jump spends one extra cycle as a no-op.
    // the word presented in that cycle was fetched before the outcome was known;
    // it is consumed and dropped rather than held back, so the fetch side never
    // stalls, at the cost of one wasted word per taken branch
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            IDE_EXEC: begin
                if (skip_taken || is_jump) begin
                    state_next = IDE_NOP_SLOT;
                end
            end
            IDE_NOP_SLOT: begin
                // only a presented word is consumed as the no-op
                if (instr_valid) begin
                    state_next = IDE_EXEC;
                end
            end
            // an illegal code falls back to normal execution rather than locking up
            default: state_next = IDE_EXEC;
        endcase
    end

    // state register; reset leaves the core ready to execute the first word
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= IDE_EXEC;
        end else begin
            state_reg <= state_next;
        end
    end

    // accumulator: destination bit 0, or the immediate or.
    // a stalled or discarded word leaves it alone, since every strobe needs exec
    always_ff @(posedge clk) begin
        if (rst) begin
            accum_reg <= ACCUM_RESET;
        end else if (is_reg_op && !dest_file) begin
            accum_reg <= alu_bus.result;
        end else if (is_or_imm) begin
            accum_reg <= alu_bus.result;
        end
    end

    // zero flag follows the 8-bit result of the flag-affecting forms;
    // the skip forms test the same result for the skip but must not leave it here
    always_ff @(posedge clk) begin
        if (rst) begin
            zero_reg <= ZERO_RESET;
        end else if (writes_zero) begin
            zero_reg <= alu_bus.result_zero;
        end
    end

    // file write strobe, registered so the write leaves from flip-flops;
    // destination bit 0 raises no write, so the file register stays as it was.
    // the write lands one edge after execution, hence the forwarding path above
    always_ff @(posedge clk) begin
        if (rst) begin
            we_reg <= 1'h0;
        end else begin
            we_reg <= is_reg_op && dest_file;
        end
    end

    // write address and data; held between writes so the port stays quiet
    always_ff @(posedge clk) begin
        if (rst) begin
            waddr_reg <= '0;
            wdata_reg <= '0;
        end else if (is_reg_op && dest_file) begin
            waddr_reg <= reg_addr;
            wdata_reg <= alu_bus.result;
        end
    end

    // program counter: next fetch address; a jump overwrites all nine bits.
    // a discarded word still advances it, as it was fetched from the old path;
    // the count wraps from the top of the 512-word space back to zero, and a
    // stall (valid low) freezes it along with the other registers, except the file write strobe, which drops low
    always_ff @(posedge clk) begin
        if (rst) begin
            pc_reg <= PC_RESET;
        end else if (is_jump) begin
            pc_reg <= jump_target;
        end else if (instr_valid) begin
            pc_reg <= PC_W'(pc_reg + 9'h001);
        end
    end

    // handshake outputs and the file read address are combinational, other data outputs registered.
    // every presented word is taken: executed in the normal slot, dropped in the
    // no-op slot, so the fetch side needs no back-pressure
    assign instr_taken = instr_valid;
    // high while the word on the port is the one being thrown away
    assign nop_slot = (state_reg == IDE_NOP_SLOT);

    // registered results straight to the ports
    assign file_we = we_reg;
    assign file_waddr = waddr_reg;
    assign file_wdata = wdata_reg;
    assign accumulator = accum_reg;
    assign zero_flag = zero_reg;
    assign program_counter = pc_reg;

endmodule // ide_core

// *** dv/ide_core_chk.sv ***
/* port checker for ide_core.
   assumes it is bound onto ide_core and sees its ports only. */
`timescale 1ns/1ns
module ide_core_chk import ide_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire logic [INSTR_W-1:0] instr_word,
    input wire logic [ADDR_W-1:0] file_raddr,
    input wire logic file_we,
    input wire logic [ADDR_W-1:0] file_waddr,
    input wire logic [DATA_W-1:0] accumulator,
    input wire logic zero_flag,
    input wire logic [PC_W-1:0] program_counter,
    input wire logic nop_slot
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // decode of executed words only; a word in the slot must leave no trace
    wire logic ex = instr_valid && !nop_slot;
    wire logic [5:0] opr = instr_word[12:7];
    wire logic jmp = ex && instr_word[12:9] == OPC_JUMP;
    wire logic ori = ex && instr_word[12:8] == OPC_OR_IMM;
    wire logic alu = ex && (opr == OPC_DECREMENT || opr == OPC_INCREMENT || opr == OPC_OR_REG);
    wire logic skp = ex && (opr == OPC_DECREMENT_SKIP || opr == OPC_INCREMENT_SKIP);
    raddr_field_a: assert property (file_raddr == instr_word[5:0])
        else $error("read address not from word");
    jump_target_a: assert property (jmp |=> program_counter == $past(instr_word[8:0]))
        else $error("jump target not loaded");
    jump_cost_a: assert property (jmp |=> nop_slot && $stable(zero_flag))
        else $error("jump not two cycles or flag moved");
    or_imm_a: assert property (ori |=> !file_we &&
        accumulator == ($past(accumulator) | $past(instr_word[7:0])))
        else $error("or immediate result wrong");
    dest_file_a: assert property (alu && instr_word[DEST_BIT] |=> file_we &&
        file_waddr == $past(instr_word[5:0]) && $stable(accumulator))
        else $error("file destination not written");
    dest_accum_a: assert property (alu && !instr_word[DEST_BIT] |=> !file_we)
        else $error("file written for accumulator destination");
    skip_flag_a: assert property (skp |=> $stable(zero_flag))
        else $error("skip form changed zero flag");
    pc_step_a: assert property (ex && !jmp |=>
        program_counter == $past(program_counter) + 9'h001)
        else $error("program counter did not step");
    cover property (skp ##1 nop_slot);
    cover property (jmp);
    cover property (alu && instr_word[DEST_BIT]);
endmodule // ide_core_chk

bind ide_core ide_core_chk u_ide_core_chk (.clk(clk), .rst(rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .file_raddr(file_raddr), .file_we(file_we),
    .file_waddr(file_waddr), .accumulator(accumulator), .zero_flag(zero_flag),
    .program_counter(program_counter), .nop_slot(nop_slot));

// *** dv/ide_core_tb.sv ***
/* self-checking bench for ide_core with a 64-byte file register model.
   assumes ide_pkg, the core, its alu and the bound checker are compiled. */
`timescale 1ns/1ns
module ide_core_tb import ide_pkg::*; ();
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic instr_valid = 1'b0;
    logic [INSTR_W-1:0] instr_word = 13'h0000;
    logic [DATA_W-1:0] mem [64];
    logic [ADDR_W-1:0] file_raddr, file_waddr;
    logic instr_taken, file_we, zero_flag, nop_slot, slot, taken;
    logic [DATA_W-1:0] file_wdata, accumulator;
    logic [PC_W-1:0] program_counter, pc1;
    int miscompares = 0, total_checks = 0, cycles = 0;
    wire logic [DATA_W-1:0] file_rdata = mem[file_raddr];

    ide_core u_ide_core (.clk(clk), .rst(rst), .instr_valid(instr_valid),
        .instr_word(instr_word), .file_rdata(file_rdata), .instr_taken(instr_taken),
        .file_raddr(file_raddr), .file_we(file_we), .file_waddr(file_waddr),
        .file_wdata(file_wdata), .accumulator(accumulator), .zero_flag(zero_flag),
        .program_counter(program_counter), .nop_slot(nop_slot));

    initial forever #20 clk = ~clk;
    initial foreach (mem[i]) mem[i] = 8'h00;
    // file model; preloads happen only while no write is pending
    always @(posedge clk) if (file_we) mem[file_waddr] <= file_wdata;
    // hang guard, far above the 56 cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        chk({8'h00, got}, {8'h00, exp});
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        chk({1'h0, got}, {1'h0, exp});
    endtask
    function automatic logic [12:0] rw(logic [5:0] opc, logic d, logic [5:0] r);
        return {opc, d, r};
    endfunction
    // two words back to back; slot and pc1 show the cycle after the first
    task automatic run2(input logic [12:0] w1, input logic [12:0] w2);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_word <= w1;
        @(posedge clk);
        instr_word <= w2;
        #1;
        slot = nop_slot;
        taken = instr_taken;
        pc1 = program_counter;
        @(posedge clk);
        instr_valid <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic t_incdec();
        mem[5] = 8'h01;
        mem[6] = 8'h80;
        mem[63] = 8'hFF;
        mem[0] = 8'h41;
        run2(rw(OPC_DECREMENT, 1'b0, 6'h05), 13'h0000);
        chk_byte(accumulator, 8'h00);
        chk_byte(mem[5], 8'h01);
        chk_flag(zero_flag, 1'b1);
        chk_flag(slot, 1'b0);
        run2(rw(OPC_DECREMENT, 1'b1, 6'h06), 13'h0000);
        chk_byte(mem[6], 8'h7F);
        chk_byte(accumulator, 8'h00);
        chk_flag(zero_flag, 1'b0);
        run2(rw(OPC_INCREMENT, 1'b1, 6'h3F), 13'h0000);
        chk_byte(mem[63], 8'h00);
        chk_flag(zero_flag, 1'b1);
        run2(rw(OPC_INCREMENT, 1'b0, 6'h00), 13'h0000);
        chk_byte(accumulator, 8'h42);
        chk_flag(slot, 1'b0);
    endtask
    task automatic t_or();
        mem[7] = 8'h0C;
        run2(rw(OPC_OR_REG, 1'b0, 6'h07), 13'h0000);
        chk_byte(accumulator, 8'h4E);
        run2(rw(OPC_OR_REG, 1'b1, 6'h07), 13'h0000);
        chk_byte(mem[7], 8'h4E);
        run2({OPC_OR_IMM, 8'h30}, 13'h0000);
        chk_byte(accumulator, 8'h7E);
        chk_flag(zero_flag, 1'b0);
    endtask
    task automatic t_skip();
        mem[8] = 8'hFF;
        run2(rw(OPC_DECREMENT_SKIP, 1'b1, 6'h05), {OPC_OR_IMM, 8'hFF});
        chk_flag(slot, 1'b1);
        chk_flag(taken, 1'b1);
        chk_byte(mem[5], 8'h00);
        chk_byte(accumulator, 8'h7E);
        chk_flag(zero_flag, 1'b0);
        run2(rw(OPC_INCREMENT_SKIP, 1'b0, 6'h3F), {OPC_OR_IMM, 8'h80});
        chk_flag(slot, 1'b0);
        chk_byte(accumulator, 8'h81);
        run2(rw(OPC_INCREMENT_SKIP, 1'b0, 6'h08), {OPC_OR_IMM, 8'h01});
        chk_flag(slot, 1'b1);
        chk_byte(accumulator, 8'h00);
        chk_flag(zero_flag, 1'b0);
    endtask
    task automatic t_jump();
        run2({OPC_JUMP, 9'h123}, {OPC_OR_IMM, 8'hFF});
        chk(pc1, 9'h123);
        chk_flag(slot, 1'b1);
        chk(program_counter, 9'h124);
        chk_byte(accumulator, 8'h00);
        chk_flag(zero_flag, 1'b0);
        run2({OPC_JUMP, 9'h1FF}, 13'h0000);
        chk(pc1, 9'h1FF);
        chk(program_counter, 9'h000);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk(program_counter, 9'h000);
        t_incdec();
        t_or();
        t_skip();
        t_jump();
        conclude();
    end
endmodule // ide_core_tb
